// [inc/fsu_defines.svh]
// Register indices, field positions, reset values and counts of the
// FIFO serial unit. Assumes inclusion by bare name from design files.
`ifndef FSU_DEFINES_SVH
`define FSU_DEFINES_SVH
// Register indices on the plain port
`define FSU_A_MODE 4'h0
`define FSU_A_BAUD 4'h1
`define FSU_A_CTRL 4'h2
`define FSU_A_TXD 4'h3
`define FSU_A_STAT 4'h4
`define FSU_A_RXD 4'h5
`define FSU_A_FCTL 4'h6
`define FSU_A_CNT 4'h7
`define FSU_A_PORT 4'h8
// Status bit positions
`define FSU_S_DR 0
`define FSU_S_RDF 1
`define FSU_S_PER 2
`define FSU_S_FER 3
`define FSU_S_BRK 4
`define FSU_S_TX_FIFO_LOW_FLAG 5
`define FSU_S_TX_END_FLAG 6
`define FSU_S_ER 7
`define FSU_STAT_RST 8'h60
`define FSU_STAT_SWCLR 8'hF3
// Control, FIFO control and port bit positions
`define FSU_C_TIE 7
`define FSU_C_RIE 6
`define FSU_C_TE 5
`define FSU_C_RE 4
`define FSU_F_RRST 0
`define FSU_F_TRST 1
`define FSU_P_LVL 0
`define FSU_P_MLO 1
`define FSU_P_MHI 2
// Trigger levels per select code
`define FSU_TTRG_0 5'h08
`define FSU_TTRG_1 5'h04
`define FSU_TTRG_2 5'h02
`define FSU_TTRG_3 5'h01
`define FSU_RTRG_0 5'h01
`define FSU_RTRG_1 5'h04
`define FSU_RTRG_2 5'h08
`define FSU_RTRG_3 5'h0E
// Depth, oversampling, timeouts, reset values
`define FSU_DEPTH 5'h10
`define FSU_PH_MID 4'h7
`define FSU_PH_LAST 4'hF
`define FSU_DR_TICKS 8'hF0
`define FSU_BAUD_RST 8'hFF
// Priority codes of the highest pending request
`define FSU_P_NONE 3'h0
`define FSU_P_ERR 3'h1
`define FSU_P_FULL 3'h2
`define FSU_P_BRK 3'h3
`define FSU_P_TXL 3'h4
`endif

// [inc/fsu_pkg.sv]
// Types shared by the FIFO serial unit.
// Assumes the defines header supplies all numeric constants.
package fsu_pkg;
    typedef struct packed {
        logic two_stop;
        logic odd;
        logic par_en;
        logic seven;
    } fsu_fmt_t;
    typedef enum logic [2:0] {
        TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP1, TX_STOP2
    } fsu_tx_st_t;
    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
    } fsu_rx_st_t;
endpackage

// [src/fsu_fifo_serial_unit.sv]
// FIFO serial unit: 16-deep FIFOs, flags, four requests, DMA triggers.
// Assumes one 10 MHz clock, synchronous reset, receive pin asynchronous.
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "fsu_defines.svh"

module fsu_fifo_serial_unit (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Serial pins
    input wire logic rxd,
    output logic txd,
    // Interrupt requests
    output logic rx_error_irq,
    output logic rx_full_irq,
    output logic break_irq,
    output logic tx_fifo_low_irq,
    output logic [2:0] irq_top,
    // DMA triggers
    output logic tx_dma_req,
    output logic rx_dma_req
);
    fsu_pkg::fsu_fmt_t fmt_r;
    fsu_pkg::fsu_tx_st_t tx_st_r;
    fsu_pkg::fsu_rx_st_t rx_st_r;
    logic [7:0] baud_r, bcnt_r, ctrl_r, fctl_r, stat_r;
    logic [2:0] port_r;
    logic [7:0] tx_mem [16];
    logic [7:0] rx_mem [16];
    logic [3:0] tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
    logic [4:0] tx_cnt_r, rx_cnt_r;
    logic [3:0] tx_ph_r, rx_ph_r;
    logic [2:0] tx_bit_r, rx_bit_r;
    logic [7:0] tx_sh_r, rx_sh_r, dr_cnt_r;
    logic tx_par_r, rx_par_r, txd_r, rxd_m_r, rxd_s_r, rxd_q_r, hold_r;
    logic [15:0] rdata_r;

    // Register decode
    wire te = ctrl_r[`FSU_C_TE];
    wire re = ctrl_r[`FSU_C_RE];
    wire tx_irq_enable = ctrl_r[`FSU_C_TIE];
    wire rx_irq_enable = ctrl_r[`FSU_C_RIE];
    wire wr_txd = reg_wr && reg_addr == `FSU_A_TXD;
    wire wr_stat = reg_wr && reg_addr == `FSU_A_STAT;
    wire rd_rxd = reg_rd && reg_addr == `FSU_A_RXD;
    wire tx_flush = fctl_r[`FSU_F_TRST];
    wire rx_flush = fctl_r[`FSU_F_RRST];

    // Trigger levels from the two select bits of each direction
    wire [1:0] tsel = fctl_r[5:4];
    wire [1:0] rsel = fctl_r[7:6];
    wire [4:0] ttrg = tsel == 2'h0 ? `FSU_TTRG_0 : tsel == 2'h1 ? `FSU_TTRG_1 :
                      tsel == 2'h2 ? `FSU_TTRG_2 : `FSU_TTRG_3;
    wire [4:0] rtrg = rsel == 2'h0 ? `FSU_RTRG_0 : rsel == 2'h1 ? `FSU_RTRG_1 :
                      rsel == 2'h2 ? `FSU_RTRG_2 : `FSU_RTRG_3;

    // Base clock: one tick per baud divide, sixteen per bit
    wire tick = bcnt_r == 8'h00;
    always_ff @(posedge core_clk) begin
        if (!rst_n || tick)
            bcnt_r <= !rst_n ? `FSU_BAUD_RST : baud_r;
        else
            bcnt_r <= bcnt_r - 8'h01;
    end

    // Receive pin synchroniser, then a per-tick sample for edge finding
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rxd_m_r <= 1'b1;
            rxd_s_r <= 1'b1;
            rxd_q_r <= 1'b1;
        end else begin
            rxd_m_r <= rxd;
            rxd_s_r <= rxd_m_r;
            if (tick)
                rxd_q_r <= rxd_s_r;
        end
    end

    // Transmitter control terms
    wire tx_full = tx_cnt_r == `FSU_DEPTH;
    wire tx_push = wr_txd && !tx_full;
    wire bit_end = tick && tx_ph_r == `FSU_PH_LAST;
    wire [2:0] last_bit = fmt_r.seven ? 3'h6 : 3'h7;
    wire in_stop = tx_st_r == fsu_pkg::TX_STOP1 || tx_st_r == fsu_pkg::TX_STOP2;
    wire stop_end = bit_end && (tx_st_r == fsu_pkg::TX_STOP2 ||
                    (tx_st_r == fsu_pkg::TX_STOP1 && !fmt_r.two_stop));
    wire tx_load = te && tx_cnt_r != 5'h00 && !tx_flush &&
                   ((tx_st_r == fsu_pkg::TX_IDLE && tick) || stop_end);
    wire [7:0] tx_head = tx_mem[tx_rp_r];
    wire [7:0] tx_data = fmt_r.seven ? {1'b0, tx_head[6:0]} : tx_head;
    wire enter_stop = bit_end && !fmt_r.par_en && tx_st_r == fsu_pkg::TX_DATA &&
                      tx_bit_r == last_bit || bit_end && tx_st_r == fsu_pkg::TX_PAR;
    // Gated by enable: a frame killed at the stop boundary never sends its stop
    wire tx_end_flag_set = te && enter_stop && tx_cnt_r == 5'h00;

    // Transmit state machine; enable low forces idle at once
    always_ff @(posedge core_clk) begin
        if (!rst_n || !te) begin
            tx_st_r <= fsu_pkg::TX_IDLE;
            tx_ph_r <= 4'h0;
            tx_bit_r <= 3'h0;
            tx_sh_r <= 8'h00;
            tx_par_r <= 1'b0;
        end else if (tx_load) begin
            tx_st_r <= fsu_pkg::TX_START;
            tx_ph_r <= 4'h0;
            tx_sh_r <= tx_data;
            tx_par_r <= ^tx_data ^ fmt_r.odd;
        end else if (tick && tx_st_r != fsu_pkg::TX_IDLE) begin
            tx_ph_r <= tx_ph_r + 4'h1;
            if (bit_end) begin
                case (tx_st_r)
                    fsu_pkg::TX_START: begin
                        tx_st_r <= fsu_pkg::TX_DATA;
                        tx_bit_r <= 3'h0;
                    end
                    fsu_pkg::TX_DATA: begin
                        tx_sh_r <= tx_sh_r >> 1;
                        tx_bit_r <= tx_bit_r + 3'h1;
                        if (tx_bit_r == last_bit)
                            tx_st_r <= fmt_r.par_en ? fsu_pkg::TX_PAR : fsu_pkg::TX_STOP1;
                    end
                    fsu_pkg::TX_PAR: tx_st_r <= fsu_pkg::TX_STOP1;
                    fsu_pkg::TX_STOP1:
                        tx_st_r <= fmt_r.two_stop ? fsu_pkg::TX_STOP2 : fsu_pkg::TX_IDLE;
                    default: tx_st_r <= fsu_pkg::TX_IDLE;
                endcase
            end
        end
    end

    // Line level; with enable low the port setting decides (break = low)
    wire brk_cfg = port_r[`FSU_P_MHI] && !port_r[`FSU_P_MLO];
    wire tx_bit = tx_st_r == fsu_pkg::TX_START ? 1'b0 :
                  tx_st_r == fsu_pkg::TX_DATA ? tx_sh_r[0] :
                  tx_st_r == fsu_pkg::TX_PAR ? tx_par_r : 1'b1;
    wire txd_nxt = te ? tx_bit : brk_cfg ? port_r[`FSU_P_LVL] : 1'b1;
    always_ff @(posedge core_clk) begin
        txd_r <= !rst_n ? 1'b1 : txd_nxt;
    end
    assign txd = txd_r;

    // Receiver: start when the line drops, or stays low after a break
    wire rx_start = re && tick && rx_st_r == fsu_pkg::RX_IDLE && !rxd_s_r &&
                    (rxd_q_r || hold_r);
    wire mid = tick && rx_st_r != fsu_pkg::RX_IDLE && rx_ph_r == `FSU_PH_MID;
    wire rx_done = mid && rx_st_r == fsu_pkg::RX_STOP;
    wire [7:0] rx_data = fmt_r.seven ? {1'b0, rx_sh_r[7:1]} : rx_sh_r;
    wire framing_error_flag = !rxd_s_r;
    wire parity_error_flag = fmt_r.par_en && (rx_par_r != (^rx_data ^ fmt_r.odd));
    wire brk_frame = framing_error_flag && rx_data == 8'h00 && !(fmt_r.par_en && rx_par_r);
    wire rx_full = rx_cnt_r == `FSU_DEPTH;
    wire rx_push = rx_done && !stat_r[`FSU_S_BRK] && !rx_full && !rx_flush;
    wire rx_pop = rd_rxd && rx_cnt_r != 5'h00;

    // Receive state machine, one decision per mid-bit sample
    always_ff @(posedge core_clk) begin
        if (!rst_n || !re) begin
            rx_st_r <= fsu_pkg::RX_IDLE;
            rx_ph_r <= 4'h0;
            rx_bit_r <= 3'h0;
            rx_sh_r <= 8'h00;
            rx_par_r <= 1'b0;
        end else if (rx_start) begin
            rx_st_r <= fsu_pkg::RX_START;
            rx_ph_r <= 4'h0;
        end else if (tick && rx_st_r != fsu_pkg::RX_IDLE) begin
            rx_ph_r <= rx_ph_r + 4'h1;
            if (mid) begin
                case (rx_st_r)
                    fsu_pkg::RX_START: begin
                        // A glitch shorter than half a bit is no start
                        rx_st_r <= rxd_s_r ? fsu_pkg::RX_IDLE : fsu_pkg::RX_DATA;
                        rx_bit_r <= 3'h0;
                    end
                    fsu_pkg::RX_DATA: begin
                        rx_sh_r <= {rxd_s_r, rx_sh_r[7:1]};
                        rx_bit_r <= rx_bit_r + 3'h1;
                        if (rx_bit_r == last_bit)
                            rx_st_r <= fmt_r.par_en ? fsu_pkg::RX_PAR : fsu_pkg::RX_STOP;
                    end
                    fsu_pkg::RX_PAR: begin
                        rx_par_r <= rxd_s_r;
                        rx_st_r <= fsu_pkg::RX_STOP;
                    end
                    default: rx_st_r <= fsu_pkg::RX_IDLE;
                endcase
            end
        end
    end

    // Break hold lets a line held low restart frames, so the flag returns
    always_ff @(posedge core_clk) begin
        if (!rst_n || rxd_s_r)
            hold_r <= 1'b0;
        else if (rx_done && brk_frame)
            hold_r <= 1'b1;
    end

    // FIFO pointers and counts; flush bits hold a FIFO empty
    wire tx_pop = tx_load;
    always_ff @(posedge core_clk) begin
        if (!rst_n || tx_flush) begin
            tx_wp_r <= 4'h0;
            tx_rp_r <= 4'h0;
            tx_cnt_r <= 5'h00;
        end else begin
            tx_wp_r <= tx_wp_r + {3'h0, tx_push};
            tx_rp_r <= tx_rp_r + {3'h0, tx_pop};
            tx_cnt_r <= tx_cnt_r + {4'h0, tx_push} - {4'h0, tx_pop};
        end
    end
    always_ff @(posedge core_clk) begin
        if (!rst_n || rx_flush) begin
            rx_wp_r <= 4'h0;
            rx_rp_r <= 4'h0;
            rx_cnt_r <= 5'h00;
        end else begin
            rx_wp_r <= rx_wp_r + {3'h0, rx_push};
            rx_rp_r <= rx_rp_r + {3'h0, rx_pop};
            rx_cnt_r <= rx_cnt_r + {4'h0, rx_push} - {4'h0, rx_pop};
        end
    end

    // Storage arrays carry no reset
    always_ff @(posedge core_clk) begin
        if (tx_push)
            tx_mem[tx_wp_r] <= reg_wdata[7:0];
        if (rx_push)
            rx_mem[rx_wp_r] <= rx_data;
    end

    // Data-ready timer: leftover bytes below trigger with a quiet line
    wire dr_arm = rx_st_r == fsu_pkg::RX_IDLE && rx_cnt_r != 5'h00 && rx_cnt_r < rtrg;
    always_ff @(posedge core_clk) begin
        if (!rst_n || !dr_arm)
            dr_cnt_r <= 8'h00;
        else if (tick && dr_cnt_r != `FSU_DR_TICKS)
            dr_cnt_r <= dr_cnt_r + 8'h01;
    end

    // Flag set and clear terms; software clears by writing zero, except the parity and framing bits
    logic [7:0] set_v, clr_v;
    always_comb begin
        set_v = 8'h00;
        set_v[`FSU_S_DR] = dr_arm && dr_cnt_r == `FSU_DR_TICKS;
        set_v[`FSU_S_RDF] = rx_cnt_r >= rtrg;
        set_v[`FSU_S_PER] = rx_done && parity_error_flag;
        set_v[`FSU_S_FER] = rx_done && framing_error_flag;
        set_v[`FSU_S_BRK] = rx_done && brk_frame;
        set_v[`FSU_S_TX_FIFO_LOW_FLAG] = tx_cnt_r <= ttrg;
        set_v[`FSU_S_TX_END_FLAG] = tx_end_flag_set;
        set_v[`FSU_S_ER] = rx_done && (framing_error_flag || parity_error_flag);
        clr_v = wr_stat ? (~reg_wdata[7:0] & `FSU_STAT_SWCLR) : 8'h00;
        // Framing and parity bits describe the latest frame only
        clr_v[`FSU_S_PER] = rx_done;
        clr_v[`FSU_S_FER] = rx_done;
    end

    // One sticky flag per bit; a set in the clearing cycle wins
    wire [7:0] stat_rst_v = `FSU_STAT_RST;
    for (genvar i = 0; i < 8; i++) begin : g_flag
        always_ff @(posedge core_clk) begin
            if (!rst_n)
                stat_r[i] <= stat_rst_v[i];
            else
                stat_r[i] <= set_v[i] | (stat_r[i] & ~clr_v[i]);
        end
    end

    // Software registers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            fmt_r <= '0;
            baud_r <= `FSU_BAUD_RST;
            ctrl_r <= 8'h00;
            fctl_r <= 8'h00;
            port_r <= 3'h0;
        end else if (reg_wr) begin
            case (reg_addr)
                `FSU_A_MODE: fmt_r <= reg_wdata[3:0];
                `FSU_A_BAUD: baud_r <= reg_wdata[7:0];
                `FSU_A_CTRL: ctrl_r <= reg_wdata[7:0];
                `FSU_A_FCTL: fctl_r <= reg_wdata[7:0];
                `FSU_A_PORT: port_r <= reg_wdata[2:0];
                default: ;
            endcase
        end
    end

    // Read selection; unmapped indices read zero
    wire [15:0] cnt_v = {3'h0, tx_cnt_r, 3'h0, rx_cnt_r};
    wire [15:0] rd_v =
        reg_addr == `FSU_A_MODE ? {12'h000, fmt_r} :
        reg_addr == `FSU_A_BAUD ? {8'h00, baud_r} :
        reg_addr == `FSU_A_CTRL ? {8'h00, ctrl_r} :
        reg_addr == `FSU_A_STAT ? {8'h00, stat_r} :
        reg_addr == `FSU_A_RXD ? {8'h00, rx_mem[rx_rp_r]} :
        reg_addr == `FSU_A_FCTL ? {8'h00, fctl_r} :
        reg_addr == `FSU_A_CNT ? cnt_v :
        reg_addr == `FSU_A_PORT ? {13'h0000, port_r} : 16'h0000;
    always_ff @(posedge core_clk) begin
        rdata_r <= (rst_n && reg_rd) ? rd_v : 16'h0000;
    end
    assign reg_rdata = rdata_r;

    // Requests: level of flag and enable, held until either clears
    assign rx_error_irq = stat_r[`FSU_S_ER] && rx_irq_enable;
    assign rx_full_irq = (stat_r[`FSU_S_RDF] || stat_r[`FSU_S_DR]) && rx_irq_enable;
    assign break_irq = stat_r[`FSU_S_BRK] && rx_irq_enable;
    assign tx_fifo_low_irq = stat_r[`FSU_S_TX_FIFO_LOW_FLAG] && tx_irq_enable;
    // Only the full and low flags may pace DMA
    assign rx_dma_req = stat_r[`FSU_S_RDF];
    assign tx_dma_req = stat_r[`FSU_S_TX_FIFO_LOW_FLAG];
    // Highest pending request
    assign irq_top = rx_error_irq ? `FSU_P_ERR : rx_full_irq ? `FSU_P_FULL :
                     break_irq ? `FSU_P_BRK : tx_fifo_low_irq ? `FSU_P_TXL :
                     `FSU_P_NONE;

    // Checks
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_tx_low_set: assert property (tx_cnt_r <= ttrg |=> stat_r[`FSU_S_TX_FIFO_LOW_FLAG])
        else $error("tx low flag not set at low count");
    a_rx_full_set: assert property (rx_cnt_r >= rtrg |=> stat_r[`FSU_S_RDF])
        else $error("rx full flag not set at trigger");
    a_rx_gate: assert property (!rx_irq_enable |-> !rx_error_irq && !rx_full_irq && !break_irq)
        else $error("rx request while disabled");
    a_te_reset: assert property (!te |=> tx_st_r == fsu_pkg::TX_IDLE)
        else $error("transmitter not reset");
    a_break_low: assert property (!te && brk_cfg && !port_r[`FSU_P_LVL] |=> !txd)
        else $error("break not driven low");
    a_tx_end_flag_stop: assert property ($rose(stat_r[`FSU_S_TX_END_FLAG]) |-> in_stop)
        else $error("tx end raised outside stop bit");
    a_brk_hold: assert property (stat_r[`FSU_S_BRK] && rx_done |=> rx_cnt_r <= $past(rx_cnt_r))
        else $error("data stored during break");
    a_err_top: assert property (rx_error_irq |-> irq_top == `FSU_P_ERR)
        else $error("error request not on top");
    a_mid_sample: assert property (rx_done |-> rx_ph_r == `FSU_PH_MID ##1 rx_st_r == fsu_pkg::RX_IDLE)
        else $error("stop not sampled mid-bit");
endmodule

// [sim/fsu_remote_xcvr.sv]
// Far-end serial transceiver model: sends frames on rxd, decodes txd.
// Assumes the unit's divider is 0, so one bit lasts 16 core clocks.
`timescale 1ns/1ps
module fsu_remote_xcvr #(
    parameter int BIT_CLKS = 16
) (
    // Clock
    input wire logic core_clk,
    // Serial pins seen from the far end
    input wire logic txd,
    output logic rxd
);
    // Mark level until the first frame
    initial rxd = 1'b1;

    // One bit for a whole bit time; called on an edge, changes land by NBA
    task automatic drive_bit(input logic b, input int n);
        rxd <= b;
        repeat (n) @(posedge core_clk);
    endtask

    // Start, data LSB first, chosen stop level, then one bit of mark
    task automatic send_frame(input logic [7:0] d, input logic stop_lvl);
        @(posedge core_clk);
        drive_bit(1'b0, BIT_CLKS);
        for (int i = 0; i < 8; i++) drive_bit(d[i], BIT_CLKS);
        drive_bit(stop_lvl, BIT_CLKS);
        drive_bit(1'b1, BIT_CLKS);
        #1;
    endtask

    // Line held low, as a break looks on the wire
    task automatic hold_low(input int n);
        @(posedge core_clk);
        drive_bit(1'b0, n);
        rxd <= 1'b1;
    endtask

    // Mid-bit decode of one frame; returns in the middle of the stop bit
    task automatic recv_frame(output logic [7:0] d, output logic start_ok);
        int guard;
        guard = 0;
        while (txd !== 1'b0 && guard < 2000) begin
            @(posedge core_clk);
            guard++;
        end
        repeat (BIT_CLKS / 2) @(posedge core_clk);
        start_ok = (txd === 1'b0);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge core_clk);
            d[i] = txd;
        end
        repeat (BIT_CLKS) @(posedge core_clk);
    endtask
endmodule

// [sim/fsu_fifo_serial_unit_tb.sv]
// Self-checking bench for the FIFO serial unit: flags, requests, pins.
// Assumes the remote transceiver model and a divider of 0.
`timescale 1ns/1ps
`include "fsu_defines.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module fsu_fifo_serial_unit_tb;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic rxd;
    logic txd;
    logic rx_error_irq, rx_full_irq, break_irq, tx_fifo_low_irq;
    logic [2:0] irq_top;
    logic tx_dma_req, rx_dma_req;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    logic [15:0] d;
    logic [7:0] rb;
    logic ok;
    logic [4:0] trig [4] = '{`FSU_TTRG_0, `FSU_TTRG_1, `FSU_TTRG_2, `FSU_TTRG_3};

    // 10 MHz clock
    always #50 core_clk = ~core_clk;

    fsu_fifo_serial_unit dut (
        .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .rxd(rxd), .txd(txd),
        .rx_error_irq(rx_error_irq), .rx_full_irq(rx_full_irq),
        .break_irq(break_irq), .tx_fifo_low_irq(tx_fifo_low_irq),
        .irq_top(irq_top), .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req)
    );

    fsu_remote_xcvr xr (.core_clk(core_clk), .txd(txd), .rxd(rxd));

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // Ends 1 ns past the taking edge, so register effects have landed
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    task automatic rdc(input logic [3:0] a, input logic [15:0] e);
        logic [15:0] v;
        rd(a, v);
        `CHK("register", e, v)
    endtask

    task automatic sbit(input int b, input logic e);
        logic [15:0] v;
        rd(`FSU_A_STAT, v);
        `CHK("status bit", e, v[b])
    endtask

    task automatic summarize();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Ceiling well above the few thousand cycles the sequence needs
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            summarize();
        end
    end

    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        rdc(`FSU_A_STAT, 16'h0060);
        rdc(`FSU_A_CNT, 16'h0000);
        `CHK("tx dma", 1'b1, tx_dma_req)
        `CHK("tx irq gated", 1'b0, tx_fifo_low_irq)
        `CHK("top none", 3'h0, irq_top)
        wr(`FSU_A_BAUD, 16'h0000);
        wr(`FSU_A_CTRL, 16'h0080);
        // Every transmit trigger code; transmitter off so the FIFO holds
        for (int s = 0; s < 4; s++) begin
            wr(`FSU_A_FCTL, {10'h000, 2'(s), 4'h2});
            wr(`FSU_A_FCTL, {10'h000, 2'(s), 4'h0});
            for (int i = 0; i < trig[s]; i++) wr(`FSU_A_TXD, 16'h0055);
            wr(`FSU_A_STAT, 16'h00DF);
            idle(2);
            sbit(`FSU_S_TX_FIFO_LOW_FLAG, 1'b1);
            `CHK("tx low irq", 1'b1, tx_fifo_low_irq)
            wr(`FSU_A_TXD, 16'h0055);
            wr(`FSU_A_STAT, 16'h00DF);
            idle(2);
            sbit(`FSU_S_TX_FIFO_LOW_FLAG, 1'b0);
            `CHK("tx dma off", 1'b0, tx_dma_req)
            rdc(`FSU_A_CNT, {3'b000, trig[s] + 5'h01, 8'h00});
        end
        // Overfill: the seventeenth byte is dropped
        wr(`FSU_A_FCTL, 16'h0002);
        wr(`FSU_A_FCTL, 16'h0000);
        repeat (17) wr(`FSU_A_TXD, 16'h0055);
        rdc(`FSU_A_CNT, 16'h1000);
        wr(`FSU_A_FCTL, 16'h0002);
        wr(`FSU_A_FCTL, 16'h0000);
        wr(`FSU_A_CTRL, 16'h0020);
        fork
            xr.recv_frame(rb, ok);
            begin
                wr(`FSU_A_TXD, 16'h00A5);
                wr(`FSU_A_STAT, 16'h00BF);
            end
        join
        `CHK("start bit", 1'b1, ok)
        `CHK("tx byte", 8'hA5, rb)
        sbit(`FSU_S_TX_END_FLAG, 1'b1);
        `CHK("stop level", 1'b1, txd)
        // Seven data bits with even parity: bit 7 dropped, parity in its place
        wr(`FSU_A_MODE, 16'h0003);
        fork
            xr.recv_frame(rb, ok);
            wr(`FSU_A_TXD, 16'h00C1);
        join
        `CHK("tx 7 bit parity", 8'h41, rb)
        wr(`FSU_A_MODE, 16'h0000);
        // Break out: port low, mode for break, then transmitter off mid-frame
        wr(`FSU_A_PORT, 16'h0000);
        wr(`FSU_A_PORT, 16'h0004);
        wr(`FSU_A_TXD, 16'h00FF);
        idle(40);
        wr(`FSU_A_CTRL, 16'h0000);
        idle(2);
        `CHK("break out", 1'b0, txd)
        idle(40);
        `CHK("break held", 1'b0, txd)
        wr(`FSU_A_PORT, 16'h0001);
        // Receive at trigger 1
        wr(`FSU_A_FCTL, 16'h0001);
        wr(`FSU_A_FCTL, 16'h0000);
        wr(`FSU_A_CTRL, 16'h0050);
        xr.send_frame(8'h3C, 1'b1);
        xr.send_frame(8'hC3, 1'b1);
        `CHK("rx irq", 1'b1, rx_full_irq)
        `CHK("rx dma", 1'b1, rx_dma_req)
        `CHK("top full", 3'h2, irq_top)
        rdc(`FSU_A_CNT, 16'h0002);
        wr(`FSU_A_STAT, 16'h00FC);
        idle(2);
        sbit(`FSU_S_RDF, 1'b1);
        rd(`FSU_A_RXD, d);
        `CHK("rx byte 1", 8'h3C, d[7:0])
        rd(`FSU_A_RXD, d);
        `CHK("rx byte 2", 8'hC3, d[7:0])
        wr(`FSU_A_STAT, 16'h00FC);
        idle(2);
        sbit(`FSU_S_RDF, 1'b0);
        `CHK("rx irq off", 1'b0, rx_full_irq)
        // One byte under trigger 4 on a quiet line: data ready alone, no DMA
        wr(`FSU_A_FCTL, 16'h0040);
        xr.send_frame(8'h5A, 1'b1);
        idle(260);
        `CHK("ready irq", 1'b1, rx_full_irq)
        `CHK("ready no dma", 1'b0, rx_dma_req)
        `CHK("top ready", 3'h2, irq_top)
        sbit(`FSU_S_DR, 1'b1);
        rd(`FSU_A_RXD, d);
        `CHK("rx byte 3", 8'h5A, d[7:0])
        wr(`FSU_A_FCTL, 16'h0000);
        wr(`FSU_A_STAT, 16'h00FC);
        // Low stop bit gives a framing error
        xr.send_frame(8'h81, 1'b0);
        `CHK("err irq", 1'b1, rx_error_irq)
        `CHK("top err", 3'h1, irq_top)
        sbit(`FSU_S_FER, 1'b1);
        wr(`FSU_A_CTRL, 16'h0010);
        `CHK("err gated", 1'b0, rx_error_irq)
        wr(`FSU_A_STAT, 16'h007F);
        // A clean frame clears framing error, so the break must set it anew
        xr.send_frame(8'h0F, 1'b1);
        sbit(`FSU_S_FER, 1'b0);
        wr(`FSU_A_FCTL, 16'h0001);
        wr(`FSU_A_FCTL, 16'h0000);
        wr(`FSU_A_STAT, 16'h00FC);
        wr(`FSU_A_CTRL, 16'h0050);
        // Break on the receive line; a break frame is stored only while the break flag is clear
        fork
            xr.hold_low(900);
            begin
                idle(400);
                `CHK("brk irq", 1'b1, break_irq)
                sbit(`FSU_S_FER, 1'b1);
                rdc(`FSU_A_CNT, 16'h0001);
                wr(`FSU_A_STAT, 16'h00EF);
                idle(250);
                sbit(`FSU_S_BRK, 1'b1);
            end
        join
        idle(200);
        // Walk the priority down by clearing one source at a time
        wr(`FSU_A_CTRL, 16'h00D0);
        `CHK("top err", 3'h1, irq_top)
        wr(`FSU_A_STAT, 16'h007F);
        `CHK("top full", 3'h2, irq_top)
        wr(`FSU_A_FCTL, 16'h0001);
        wr(`FSU_A_FCTL, 16'h0000);
        wr(`FSU_A_STAT, 16'h00FC);
        `CHK("top brk", 3'h3, irq_top)
        wr(`FSU_A_STAT, 16'h00EF);
        `CHK("top txl", 3'h4, irq_top)
        `CHK("txl irq", 1'b1, tx_fifo_low_irq)
        `CHK("brk off", 1'b0, break_irq)
        summarize();
    end
endmodule
